/* rtl/crbi_bank.sv */
// Host register bank mirroring the configuration ROM header and bus info quadlets
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "crbi_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Header register is ROM's first quadlet
// R2: Software loads lengths, capabilities before enabling link
// R3: Software keeps CRC valid while link enabled
// R4: EEPROM CRC loaded into header at init
// R5: CRC reset value undefined without EEPROM
// R6: Bus ID constant, read-only, first info quadlet
// R7: Options register is second info quadlet
// R8: Bit 31 writable resource-manager capable flag
// R9: Bit 30 writable cycle-master capable flag
// R10: Reserved bits zero, link speed reads 010
module crbi_bank
   import crbi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic eeprom_present,
   input wire logic eeprom_crc_valid,
   input wire logic [15:0] eeprom_crc,
   input wire logic rom_req,
   input wire logic [47:0] rom_addr,
   output logic rom_ack,
   output logic rom_hit,
   output logic [31:0] rom_data,
   output logic link_active_control
);
   typedef struct packed {
      crbi_bus_state_t bus;
      logic [31:0] readdata;
      logic waitreq;
      logic [31:0] header;
      logic [31:0] options;
      logic link_on;
      logic crc_loaded;
      logic crc_written;
   } crbi_bank_state_t;

   crbi_bank_state_t st;
   crbi_bank_state_t next_st;
   crbi_rom_if rom_bus ();

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] crbi_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] be,
                                              input logic [31:0] rw_mask);
      logic [31:0] lane_mask;
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw_mask;
      return (old_val & ~lane_mask) | (new_val & lane_mask);
   endfunction : crbi_merge

   function automatic logic [31:0] crbi_options_view(input logic [31:0] opt);
      return (opt & `CRBI_OPT_RW_MASK) | `CRBI_LINK_SPEED; // R10
   endfunction : crbi_options_view

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_st = st;
      next_st.waitreq = 1'b1;
      case (st.bus)
         CRBI_IDLE:
         begin
            if (avs_write)
            begin
               case (avs_address)
                  `CRBI_OFS_HEADER:
                  begin
                     next_st.header = crbi_merge(st.header, avs_writedata,
                                                 avs_byteenable, 32'hFFFFFFFF); // R1
                     if (avs_byteenable[1:0] != 2'b00)
                        next_st.crc_written = 1'b1;
                  end
                  `CRBI_OFS_OPTIONS:
                     next_st.options = crbi_merge(st.options, avs_writedata,
                                                  avs_byteenable, `CRBI_OPT_RW_MASK); // R8 R9
                  `CRBI_OFS_LINK_CTRL:
                     if (avs_byteenable[0])
                        next_st.link_on = avs_writedata[0];
                  default:
                     next_st.header = st.header;
               endcase
               next_st.bus = CRBI_ANSWER;
               next_st.waitreq = 1'b0;
            end
            else if (avs_read)
            begin
               case (avs_address)
                  `CRBI_OFS_HEADER: next_st.readdata = st.header;
                  `CRBI_OFS_BUS_ID: next_st.readdata = `CRBI_BUS_ID_VALUE; // R6
                  `CRBI_OFS_OPTIONS: next_st.readdata = crbi_options_view(st.options); // R10
                  `CRBI_OFS_LINK_CTRL: next_st.readdata = {31'h0, st.link_on};
                  `CRBI_OFS_STATUS:
                     next_st.readdata = {29'h0, st.crc_written, st.crc_loaded, eeprom_present};
                  default: next_st.readdata = `CRBI_UNMAPPED_DATA;
               endcase
               next_st.bus = CRBI_ANSWER;
               next_st.waitreq = 1'b0;
            end
         end
         CRBI_ANSWER:
            next_st.bus = CRBI_IDLE;
         default:
            next_st.bus = CRBI_IDLE;
      endcase
      // Late EEPROM data must not overwrite a value software already wrote
      if (eeprom_present && eeprom_crc_valid && !st.crc_loaded && !next_st.crc_written)
      begin
         next_st.header[`CRBI_CRC_MSB:`CRBI_CRC_LSB] = eeprom_crc; // R4
         next_st.crc_loaded = 1'b1;
      end
      // Sync reset; CRC half holds, undefined until loaded or written
      if (sys_rst)
      begin
         next_st.bus = CRBI_IDLE;
         next_st.readdata = 32'h00000000;
         next_st.waitreq = 1'b1;
         next_st.header[31:16] = `CRBI_HDR_RESET_HI;
         next_st.header[15:0] = st.header[15:0]; // R5
         next_st.options = `CRBI_OPT_RESET;
         next_st.link_on = 1'b0;
         next_st.crc_loaded = 1'b0;
         next_st.crc_written = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset values are chosen in the comb process, so one register process owns all state
   always_ff @(posedge clk)
   begin
      if (sys_rst || clk_en)
         st <= next_st;
   end

   assign avs_readdata = st.readdata;
   assign avs_waitrequest = st.waitreq;
   assign link_active_control = st.link_on;

   ////////////////////////////////////////////////////////////////////////////
   assign rom_bus.req = rom_req;
   assign rom_bus.addr = rom_addr;
   assign rom_ack = rom_bus.ack;
   assign rom_hit = rom_bus.hit;
   assign rom_data = rom_bus.data;

   crbi_rom_port u_rom_port (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .header(st.header),
      .options(crbi_options_view(st.options)),
      .rom(rom_bus.bank)
   );

   ////////////////////////////////////////////////////////////////////////////
   a_busid_read_const: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.bus == CRBI_IDLE && !avs_write && avs_read && avs_address == `CRBI_OFS_BUS_ID)
      |=> (!avs_waitrequest && avs_readdata == `CRBI_BUS_ID_VALUE))
      else $error("bus id read not constant"); // R6
   a_options_low_bits: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.bus == CRBI_IDLE && !avs_write && avs_read && avs_address == `CRBI_OFS_OPTIONS)
      |=> (avs_readdata[11:8] == 4'h0 && avs_readdata[5:0] == 6'h02
           && avs_readdata[26:24] == 3'h0))
      else $error("options reserved or speed bits wrong"); // R10
   a_irmc_write: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.bus == CRBI_IDLE && avs_write && avs_address == `CRBI_OFS_OPTIONS
       && avs_byteenable[3])
      |=> (st.options[`CRBI_IRMC_BIT] == $past(avs_writedata[31])))
      else $error("resource manager flag not written"); // R8
   a_cmc_write: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.bus == CRBI_IDLE && avs_write && avs_address == `CRBI_OFS_OPTIONS
       && avs_byteenable[3])
      |=> (st.options[`CRBI_CMC_BIT] == $past(avs_writedata[30])))
      else $error("cycle master flag not written"); // R9
   a_header_write: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.bus == CRBI_IDLE && avs_write && avs_address == `CRBI_OFS_HEADER
       && avs_byteenable == 4'hF)
      |=> (st.header == $past(avs_writedata)))
      else $error("header write lost"); // R1
   a_eeprom_crc_load: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && eeprom_present && eeprom_crc_valid && !st.crc_loaded && !st.crc_written
       && !(avs_write && avs_address == `CRBI_OFS_HEADER))
      |=> (st.crc_loaded && st.header[15:0] == $past(eeprom_crc)))
      else $error("eeprom crc not loaded"); // R4
   a_bus_answer_one: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && st.bus == CRBI_IDLE && (avs_read || avs_write))
      |=> !avs_waitrequest ##1 (avs_waitrequest || !$past(clk_en)))
      else $error("bus answer not one cycle"); // local design decision: Avalon-MM port
   a_rom_ack_follow: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && rom_req) |=> rom_ack)
      else $error("rom read not acknowledged"); // R1
endmodule : crbi_bank

/* rtl/crbi_consts.svh */
// Offsets, field positions and reset values of the bus info registers
`ifndef CRBI_CONSTS_SVH
`define CRBI_CONSTS_SVH
`define CRBI_OFS_HEADER 8'h18
`define CRBI_OFS_BUS_ID 8'h1C
`define CRBI_OFS_OPTIONS 8'h20
`define CRBI_OFS_LINK_CTRL 8'h24
`define CRBI_OFS_STATUS 8'h28
`define CRBI_ROM_HEADER_ADDR 48'hFFFFF0000400
`define CRBI_ROM_BUS_ID_ADDR 48'hFFFFF0000404
`define CRBI_ROM_OPTIONS_ADDR 48'hFFFFF0000408
`define CRBI_BUS_ID_VALUE 32'h31333934
`define CRBI_HDR_RESET_HI 16'h0000
`define CRBI_CRC_LSB 0
`define CRBI_CRC_MSB 15
`define CRBI_IRMC_BIT 31
`define CRBI_CMC_BIT 30
`define CRBI_OPT_RW_MASK 32'hF8FFF0C0
`define CRBI_OPT_RESET 32'h0000A002
`define CRBI_LINK_SPEED 32'h00000002
`define CRBI_UNMAPPED_DATA 32'h00000000
`endif

/* rtl/crbi_pkg.sv */
// Types shared by the bus info register bank
package crbi_pkg;
   typedef enum logic [1:0] {
      CRBI_IDLE = 2'b00,
      CRBI_ANSWER = 2'b01
   } crbi_bus_state_t;
endpackage : crbi_pkg

/* rtl/crbi_rom_if.sv */
// Remote configuration ROM read request and answer
`timescale 1ns/1ps
interface crbi_rom_if;
   logic req;
   logic [47:0] addr;
   logic ack;
   logic hit;
   logic [31:0] data;
   modport bank (input req, input addr, output ack, output hit, output data);
   modport reader (output req, output addr, input ack, input hit, input data);
endinterface : crbi_rom_if

/* rtl/crbi_rom_port.sv */
// Remote read path into the first three configuration ROM quadlets
`timescale 1ns/1ps
`include "crbi_consts.svh"
module crbi_rom_port
   import crbi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [31:0] header,
   input wire logic [31:0] options,
   crbi_rom_if.bank rom
);
   typedef struct packed {
      logic ack;
      logic hit;
      logic [31:0] data;
   } crbi_port_state_t;

   crbi_port_state_t st;
   crbi_port_state_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.ack = rom.req;
      next_st.hit = 1'b0;
      next_st.data = `CRBI_UNMAPPED_DATA;
      if (rom.req)
      begin
         case (rom.addr)
            `CRBI_ROM_HEADER_ADDR:
            begin
               next_st.hit = 1'b1;
               next_st.data = header; // R1
            end
            `CRBI_ROM_BUS_ID_ADDR:
            begin
               next_st.hit = 1'b1;
               next_st.data = `CRBI_BUS_ID_VALUE; // R6
            end
            `CRBI_ROM_OPTIONS_ADDR:
            begin
               next_st.hit = 1'b1;
               next_st.data = options; // R7
            end
            default:
            begin
               next_st.hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         st <= '0;
      else if (clk_en)
         st <= next_st;
   end

   assign rom.ack = st.ack;
   assign rom.hit = st.hit;
   assign rom.data = st.data;

   a_rom_header_read: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && rom.req && rom.addr == `CRBI_ROM_HEADER_ADDR) |=> (rom.data == $past(header)))
      else $error("header quadlet read wrong"); // R1
   a_rom_busid_read: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && rom.req && rom.addr == `CRBI_ROM_BUS_ID_ADDR)
      |=> (rom.hit && rom.data == `CRBI_BUS_ID_VALUE))
      else $error("bus id quadlet read wrong"); // R6
   a_rom_options_read: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && rom.req && rom.addr == `CRBI_ROM_OPTIONS_ADDR) |=> (rom.data == $past(options)))
      else $error("options quadlet read wrong"); // R7
endmodule : crbi_rom_port

/* tb/crbi_remote_node.sv */
// Remote bus node model that reads configuration ROM quadlets
`timescale 1ns/1ps
module crbi_remote_node (
   input wire logic clk,
   output logic rom_req,
   output logic [47:0] rom_addr,
   input wire logic rom_ack,
   input wire logic rom_hit,
   input wire logic [31:0] rom_data
);
   initial
   begin
      rom_req = 1'b0;
      rom_addr = 48'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Idle address is inverted so a stale address never looks like a request
   task automatic read_quad(input logic [47:0] a, output logic [31:0] d, output logic h,
      output logic ok);
      int i;
      @(posedge clk);
      rom_req <= 1'b1;
      rom_addr <= a;
      @(posedge clk);
      rom_req <= 1'b0;
      rom_addr <= ~a;
      ok = 1'b0;
      for (i = 0; i < 8 && !ok; i++)
      begin
         @(posedge clk);
         if (rom_ack === 1'b1)
         begin
            d = rom_data;
            h = rom_hit;
            ok = 1'b1;
         end
      end
   endtask : read_quad
endmodule : crbi_remote_node

/* tb/tb_config_rom_bus_info_regs.sv */
// Self-checking bench for the bus info register bank
`timescale 1ns/1ps
module tb_config_rom_bus_info_regs;
   logic clk, sys_rst, clk_en, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rom_data, v;
   logic eeprom_present, eeprom_crc_valid, rom_req, rom_ack, rom_hit, link_active_control;
   logic [15:0] eeprom_crc;
   logic [47:0] rom_addr;
   logic [31:0] ow [4] = '{32'hFFFFFFFF, 32'h80000000, 32'h40000000, 32'h0000003D};
   int miscompares = 0;
   int n_tests = 0;
   always #2 clk = ~clk;
   crbi_bank u_crbi_bank (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .eeprom_present(eeprom_present), .eeprom_crc_valid(eeprom_crc_valid),
      .eeprom_crc(eeprom_crc), .rom_req(rom_req), .rom_addr(rom_addr), .rom_ack(rom_ack),
      .rom_hit(rom_hit), .rom_data(rom_data), .link_active_control(link_active_control));
   crbi_remote_node u_crbi_remote_node (.clk(clk), .rom_req(rom_req), .rom_addr(rom_addr),
      .rom_ack(rom_ack), .rom_hit(rom_hit), .rom_data(rom_data));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic hang;
      miscompares++;
      $display("FAIL %0t no answer", $time);
      summarize();
   endtask : hang
   // Request held until waitrequest is sampled low, for up to 50 cycles of slave latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      input logic [3:0] be, output logic [31:0] rd);
      int i;
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 50)
         hang();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] x;
      bus(1'b1, a, d, be, x);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h00000000, 4'hF, x);
      check(x, exp);
   endtask : rdchk
   task automatic romchk(input logic [47:0] a, input logic eh, input logic [31:0] ed);
      logic [31:0] d;
      logic h, ok;
      u_crbi_remote_node.read_quad(a, d, h, ok);
      if (!ok)
         hang();
      check({31'h0, h}, {31'h0, eh});
      check(d, ed);
   endtask : romchk
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
      {eeprom_present, eeprom_crc_valid, eeprom_crc} = '0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      // CRC half is left out: it has no defined value without an EEPROM
      bus(1'b0, 8'h18, 32'h00000000, 4'hF, v);
      check({v[31:16], 16'h0000}, 32'h00000000);
      rdchk(8'h1C, 32'h31333934);
      rdchk(8'h20, 32'h0000A002);
      rdchk(8'h00, 32'h00000000);
      done("reset");
      wr(8'h1C, 32'hFFFFFFFF, 4'hF);
      rdchk(8'h1C, 32'h31333934);
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h20, ow[k], 4'hF);
         rdchk(8'h20, (ow[k] & 32'hF8FFF0C0) | 32'h00000002);
      end
      done("options");
      wr(8'h18, 32'h12345678, 4'hF);
      rdchk(8'h18, 32'h12345678);
      romchk(48'hFFFFF0000400, 1'b1, 32'h12345678);
      wr(8'h18, 32'hAABBCCDD, 4'b0001);
      romchk(48'hFFFFF0000400, 1'b1, 32'h123456DD);
      rdchk(8'h28, 32'h00000004);
      romchk(48'hFFFFF0000404, 1'b1, 32'h31333934);
      wr(8'h20, 32'hC0000000, 4'hF);
      romchk(48'hFFFFF0000408, 1'b1, 32'hC0000002);
      romchk(48'hFFFFF000040C, 1'b0, 32'h00000000);
      done("remote");
      // Frozen clock enable only stretches the wait
      clk_en <= 1'b0;
      fork
         begin
            repeat (6) @(posedge clk);
            clk_en <= 1'b1;
         end
      join_none
      rdchk(8'h1C, 32'h31333934);
      wr(8'h24, 32'h00000001, 4'hF);
      check({31'h0, link_active_control}, 32'h00000001);
      done("control");
      sys_rst <= 1'b1;
      eeprom_present <= 1'b1;
      eeprom_crc <= 16'hBEEF;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      eeprom_crc_valid <= 1'b1;
      @(posedge clk);
      eeprom_crc_valid <= 1'b0;
      rdchk(8'h18, 32'h0000BEEF);
      romchk(48'hFFFFF0000400, 1'b1, 32'h0000BEEF);
      rdchk(8'h28, 32'h00000003);
      done("eeprom");
      summarize();
   end
endmodule : tb_config_rom_bus_info_regs
